// file: ssaw_pkg.sv
/*
 * ssaw_pkg: widths, reset values and enumerations shared by the
 * synchronous sram address capture and write control front end.
 * assumes a single rising-edge clock domain for every user.
 */
`default_nettype none

package ssaw_pkg;

	localparam int ADDR_W    = 17;      // 128K word locations
	localparam int CNT_W     = 2;       // burst counter width
	localparam int HIGH_W    = ADDR_W - CNT_W;
	localparam int LANES     = 4;       // byte lanes a to d
	localparam int LANE_W    = 8;
	localparam int DATA_W    = LANES * LANE_W;
	localparam int WORD_LOCS = 131072;  // 128K

	typedef logic [ADDR_W-1:0] ssaw_addr_t;
	typedef logic [HIGH_W-1:0] ssaw_high_t;
	typedef logic [CNT_W-1:0]  ssaw_cnt_t;
	typedef logic [LANES-1:0]  ssaw_lane_t;
	typedef logic [DATA_W-1:0] ssaw_data_t;

	localparam ssaw_high_t HIGH_RST  = 15'h0000;
	localparam ssaw_cnt_t  CNT_RST   = 2'h0;
	localparam ssaw_cnt_t  CNT_STEP  = 2'h1;
	localparam ssaw_lane_t ALL_LANES = 4'hf;
	localparam ssaw_lane_t NO_LANES  = 4'h0;
	localparam ssaw_data_t DATA_RST  = 32'h0000_0000;

	// which strobe, if any, is recognised on an edge
	typedef enum logic [1:0] {
		LD_NONE,
		LD_PROC,
		LD_CTRL,
		LD_DESEL
	} ssaw_load_e;

endpackage : ssaw_pkg

`default_nettype wire

// file: ssaw_burst_ctr.sv
/*
 * ssaw_burst_ctr: two-bit burst counter supplying the low word address.
 * assumes load and advance come from logic on the same clock; load wins.
 */
`timescale 1ns/100ps
`default_nettype none

module ssaw_burst_ctr
	import ssaw_pkg::*;
(
	input  wire logic             mclk,     // core clock
	input  wire logic             sys_rst,  // synchronous reset
	input  wire logic             load,     // take loadVal this edge
	input  wire ssaw_pkg::ssaw_cnt_t loadVal,  // low address bits
	input  wire logic             advance,  // step by one
	output var ssaw_pkg::ssaw_cnt_t count    // current low address
);
	import ssaw_pkg::*;

	ssaw_cnt_t count_ff;
	ssaw_cnt_t nxt_count;

	always_comb
	begin
		nxt_count = count_ff;
		if (load)
			nxt_count = loadVal;
		else if (advance)
			nxt_count = count_ff + CNT_STEP;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			count_ff <= CNT_RST;
		else
			count_ff <= nxt_count;
	end

	assign count = count_ff;

endmodule : ssaw_burst_ctr

`default_nettype wire

// file: ssaw_front_end.sv
/*
 * ssaw_front_end: address capture and byte-lane write control of a
 * synchronous pipelined burst sram, 128K words of four byte lanes.
 * assumes every pin input is driven by logic on mclk and meets setup
 * to the rising edge, so no synchroniser is placed on them.
 */
// Function
// - captured word address selects one of 128K
// - capture address on strobe with chips selected
// - load low two bits into burst counter
// - byte selects honoured only with qualifier low
// - qualifier low with global write high writes only lanes selected low
// - global write low writes every lane
// - processor strobe wins over controller strobe while select one is low
// - selects 1,3 low, 2 high, load only
// - advance low steps burst counter
// - write data and parity registered each edge
`timescale 1ns/100ps
`default_nettype none

module ssaw_front_end
	import ssaw_pkg::*;
(
	input  wire logic                mclk,                      // core clock, 250 MHz
	input  wire logic                sys_rst,                   // synchronous reset, high
	input  wire ssaw_pkg::ssaw_addr_t addrIn,                   // word address pins
	input  wire logic                processor_addr_strobe_n,   // processor strobe
	input  wire logic                controller_addr_strobe_n,  // controller strobe
	input  wire logic                chip_select_first_n,       // chip select one
	input  wire logic                chip_select_second,        // chip select two
	input  wire logic                chip_select_third_n,       // chip select three
	input  wire logic                burst_advance_n,           // burst step request
	input  wire ssaw_pkg::ssaw_lane_t byte_lane_write_select_n, // lane selects a..d
	input  wire logic                byte_write_qualifier_n,    // byte write enable
	input  wire logic                all_lanes_write_n,         // global write
	input  wire ssaw_pkg::ssaw_data_t dataIn,                   // data pins, input side
	input  wire ssaw_pkg::ssaw_lane_t lane_parity_in,           // parity pins, input side
	output var ssaw_pkg::ssaw_addr_t  wordAddr,                  // access word address
	output logic                     accessSelected,            // device selected
	output var ssaw_pkg::ssaw_lane_t  laneWriteEn,               // per-lane write strobe
	output var ssaw_pkg::ssaw_data_t  writeData,                 // registered write data
	output var ssaw_pkg::ssaw_lane_t  writeParity                // registered lane parity
);
	import ssaw_pkg::*;

	ssaw_load_e loadSrc;
	logic       chipsActive;
	logic       doLoad;
	logic       doAdvance;
	ssaw_cnt_t  burstCount;

	ssaw_high_t addrHigh_ff;
	ssaw_high_t nxt_addrHigh;
	logic       selected_ff;
	logic       nxt_selected;
	ssaw_lane_t laneWe_ff;
	ssaw_lane_t nxt_laneWe;
	ssaw_data_t wData_ff;
	ssaw_data_t nxt_wData;
	ssaw_lane_t wPar_ff;
	ssaw_lane_t nxt_wPar;

	// chip selects matter only on an edge with a recognised address strobe
	assign chipsActive = !chip_select_first_n && chip_select_second && !chip_select_third_n;

	// processor strobe is dropped when select one is high, letting the
	// controller strobe through; otherwise it shadows the controller
	always_comb
	begin
		if (!processor_addr_strobe_n && !chip_select_first_n)
			loadSrc = chipsActive ? LD_PROC : LD_DESEL;
		else if (!controller_addr_strobe_n)
			loadSrc = chipsActive ? LD_CTRL : LD_DESEL;
		else
			loadSrc = LD_NONE;
	end

	assign doLoad    = (loadSrc == LD_PROC) || (loadSrc == LD_CTRL);
	// a burst only steps while selected and no new address is offered
	assign doAdvance = (loadSrc == LD_NONE) && selected_ff && !burst_advance_n;

	ssaw_burst_ctr u_burst_ctr
	(
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.load    (doLoad),
		.loadVal (addrIn[CNT_W-1:0]),
		.advance (doAdvance),
		.count   (burstCount)
	);

	always_comb
	begin
		nxt_addrHigh = addrHigh_ff;
		nxt_selected = selected_ff;
		unique case (loadSrc)
			LD_PROC, LD_CTRL:
			begin
				nxt_addrHigh = addrIn[ADDR_W-1:CNT_W];
				nxt_selected = 1'b1;
			end
			LD_DESEL:
				nxt_selected = 1'b0;
			LD_NONE:
				nxt_selected = selected_ff;
		endcase
	end

	// writes take effect on the address in force after this edge; a
	// deselected device never writes, whatever the write pins say
	always_comb
	begin
		nxt_laneWe = NO_LANES;
		if (nxt_selected)
		begin
			if (!all_lanes_write_n)
				nxt_laneWe = ALL_LANES;
			else if (!byte_write_qualifier_n)
				nxt_laneWe = ~byte_lane_write_select_n;
		end
	end

	always_comb
	begin
		nxt_wData = dataIn;
		nxt_wPar  = lane_parity_in;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			addrHigh_ff <= HIGH_RST;
			selected_ff <= 1'b0;
			laneWe_ff   <= NO_LANES;
			wData_ff    <= DATA_RST;
			wPar_ff     <= NO_LANES;
		end
		else
		begin
			addrHigh_ff <= nxt_addrHigh;
			selected_ff <= nxt_selected;
			laneWe_ff   <= nxt_laneWe;
			wData_ff    <= nxt_wData;
			wPar_ff     <= nxt_wPar;
		end
	end

	// 17 bits reach exactly the 128K words, no wider decode is needed
	assign wordAddr       = {addrHigh_ff, burstCount};
	assign accessSelected = selected_ff;
	assign laneWriteEn    = laneWe_ff;
	assign writeData      = wData_ff;
	assign writeParity    = wPar_ff;

	property p_procCapture;
		@(posedge mclk) disable iff (sys_rst)
		(!processor_addr_strobe_n && chipsActive)
		|=> (wordAddr == $past(addrIn)) && accessSelected;
	endproperty
	a_procCapture: assert property (p_procCapture)
		else $error("processor strobe did not capture address");

	property p_ctrlCapture;
		@(posedge mclk) disable iff (sys_rst)
		(processor_addr_strobe_n && !controller_addr_strobe_n && chipsActive)
		|=> (wordAddr == $past(addrIn)) && accessSelected;
	endproperty
	a_ctrlCapture: assert property (p_ctrlCapture)
		else $error("controller strobe did not capture address");

	property p_procWins;
		@(posedge mclk) disable iff (sys_rst)
		(!processor_addr_strobe_n && !controller_addr_strobe_n && !chip_select_first_n)
		|-> (loadSrc != LD_CTRL) ##1 (accessSelected == $past(chipsActive));
	endproperty
	a_procWins: assert property (p_procWins)
		else $error("controller strobe acted beside processor strobe");

	property p_noStrobeHold;
		@(posedge mclk) disable iff (sys_rst)
		(processor_addr_strobe_n && controller_addr_strobe_n)
		|=> $stable(addrHigh_ff) && $stable(accessSelected);
	endproperty
	a_noStrobeHold: assert property (p_noStrobeHold)
		else $error("address or select moved without a strobe");

	property p_advance;
		@(posedge mclk) disable iff (sys_rst)
		(processor_addr_strobe_n && controller_addr_strobe_n && accessSelected && !burst_advance_n)
		|=> (wordAddr[CNT_W-1:0] == $past(wordAddr[CNT_W-1:0]) + CNT_STEP)
			&& (wordAddr[ADDR_W-1:CNT_W] == $past(wordAddr[ADDR_W-1:CNT_W]));
	endproperty
	a_advance: assert property (p_advance)
		else $error("burst counter did not step");

	property p_globalWrite;
		@(posedge mclk) disable iff (sys_rst)
		!all_lanes_write_n |=> laneWriteEn == (accessSelected ? ALL_LANES : NO_LANES);
	endproperty
	a_globalWrite: assert property (p_globalWrite)
		else $error("global write missed a lane");

	property p_byteWrite;
		@(posedge mclk) disable iff (sys_rst)
		(all_lanes_write_n && !byte_write_qualifier_n)
		|=> laneWriteEn == (accessSelected ? ~$past(byte_lane_write_select_n) : NO_LANES);
	endproperty
	a_byteWrite: assert property (p_byteWrite)
		else $error("byte write lanes wrong");

	property p_readNoWrite;
		@(posedge mclk) disable iff (sys_rst)
		(all_lanes_write_n && byte_write_qualifier_n) |=> laneWriteEn == NO_LANES;
	endproperty
	a_readNoWrite: assert property (p_readNoWrite)
		else $error("lane written on a read cycle");

	property p_dataCapture;
		@(posedge mclk) disable iff (sys_rst)
		1'b1 |=> (writeData == $past(dataIn)) && (writeParity == $past(lane_parity_in));
	endproperty
	a_dataCapture: assert property (p_dataCapture)
		else $error("write data not registered");

	property p_addrRange;
		@(posedge mclk) disable iff (sys_rst)
		(processor_addr_strobe_n && controller_addr_strobe_n && (burst_advance_n || !accessSelected))
		|=> $stable(wordAddr) && (32'(wordAddr) < WORD_LOCS);
	endproperty
	a_addrRange: assert property (p_addrRange)
		else $error("word address moved while idle");

endmodule : ssaw_front_end

`default_nettype wire

// file: ssaw_ctrl_model.sv
/*
 * ssaw_ctrl_model: behavioural controller on the pin side of the front end.
 * assumes the bench calls drive once a cycle, just after a rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module ssaw_ctrl_model
	import ssaw_pkg::*;
(
	output logic                     psN,       // processor strobe
	output logic                     csN,       // controller strobe
	output logic                     c1N,       // chip select one
	output logic                     c2,        // chip select two
	output logic                     c3N,       // chip select three
	output logic                     stepN,     // burst step
	output var ssaw_pkg::ssaw_lane_t laneSelN,  // lane selects
	output logic                     byteQualN, // byte write qualifier
	output logic                     allWrN,    // global write
	output var ssaw_pkg::ssaw_addr_t addr,      // word address
	output var ssaw_pkg::ssaw_data_t data,      // write data
	output var ssaw_pkg::ssaw_lane_t par        // lane parity
);
	import ssaw_pkg::*;

	initial
	begin
		{psN, csN, c1N, c2, c3N, stepN, laneSelN, byteQualN, allWrN} = 12'hf7f;
		addr = 17'h0;
		data = 32'h0;
		par = 4'h0;
	end

	// v = {proc, ctrl, cs1, cs2, cs3, step, lanes[3:0], qualifier, global}
	task automatic drive(input logic [11:0] v, input ssaw_addr_t a, input ssaw_data_t d, input ssaw_lane_t p);
		{psN, csN, c1N, c2, c3N, stepN, laneSelN} = v[11:2];
		byteQualN = v[1];
		allWrN = v[0];
		addr = a;
		data = d;
		par = p;
	endtask : drive
endmodule : ssaw_ctrl_model

`default_nettype wire

// file: tb.sv
/*
 * tb: self-checking bench for the front end with a reference model.
 * assumes one clock, outputs checked on the falling edge after the sampling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
	import ssaw_pkg::*;
	logic        mclk = 1'b0;
	logic        sysRst = 1'b1;
	logic        psN, csN, c1N, c2, c3N, stepN, byteQualN, allWrN, sel;
	ssaw_lane_t  laneSelN, par, lwe, wp;
	ssaw_addr_t  addr, wa, eAddr;
	ssaw_data_t  data, wd;
	logic        eSel;
	logic [57:0] expQ[$];
	logic [57:0] exp, got;
	logic [31:0] rng = 32'h4d;
	int          n_mismatch, tests_run, cyc;

	always #2 mclk = ~mclk;

	ssaw_ctrl_model i_ssaw_ctrl_model (.psN(psN), .csN(csN), .c1N(c1N), .c2(c2), .c3N(c3N), .stepN(stepN),
		.laneSelN(laneSelN), .byteQualN(byteQualN), .allWrN(allWrN), .addr(addr), .data(data), .par(par));

	ssaw_front_end i_ssaw_front_end (.mclk(mclk), .sys_rst(sysRst), .addrIn(addr),
		.processor_addr_strobe_n(psN), .controller_addr_strobe_n(csN), .chip_select_first_n(c1N),
		.chip_select_second(c2), .chip_select_third_n(c3N), .burst_advance_n(stepN),
		.byte_lane_write_select_n(laneSelN), .byte_write_qualifier_n(byteQualN), .all_lanes_write_n(allWrN),
		.dataIn(data), .lane_parity_in(par), .wordAddr(wa), .accessSelected(sel),
		.laneWriteEn(lwe), .writeData(wd), .writeParity(wp));

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd

	task automatic stop_test;
		$display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	// entered just after a rising edge; notes what the next edge must produce
	task automatic step(input logic [11:0] v);
		ssaw_addr_t a;
		ssaw_data_t d;
		ssaw_lane_t p;
		ssaw_lane_t lw;
		a = ssaw_addr_t'(rnd());
		d = rnd();
		p = ssaw_lane_t'(rnd());
		i_ssaw_ctrl_model.drive(v, a, d, p);
		if ((!v[11] && !v[9]) || !v[10])
		begin
			eSel = !v[9] && v[8] && !v[7];
			if (eSel)
				eAddr = a;
		end
		else if (eSel && !v[6])
			eAddr[1:0] = eAddr[1:0] + 2'h1;
		lw = !eSel ? 4'h0 : !v[0] ? 4'hf : !v[1] ? ~v[5:2] : 4'h0;
		@(posedge mclk);
		expQ.push_back({eSel, lw, d, p, eSel ? eAddr : 17'h0});
		#1;
	endtask : step

	// mid-run reset with idle pins: every output must read zero on the reset
	// edge and on the first edge after it; no request until the next cycle
	task automatic pulse_reset;
		i_ssaw_ctrl_model.drive(12'hfff, 17'h0, 32'h0, 4'h0);
		sysRst = 1'b1;
		@(posedge mclk);
		expQ.push_back(58'h0);
		#1;
		sysRst = 1'b0;
		eSel = 1'b0;
		eAddr = 17'h0;
		@(posedge mclk);
		expQ.push_back(58'h0);
		#1;
	endtask : pulse_reset

	always @(negedge mclk)
		if (expQ.size() > 0)
		begin
			exp = expQ.pop_front();
			got = {sel, lwe, wd, wp, sel ? wa : 17'h0};
			tests_run++;
			if (got !== exp)
			begin
				n_mismatch++;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	initial
	begin
		logic [11:0] v;
		eSel = 1'b0;
		eAddr = 17'h0;
		repeat (12) @(posedge mclk);
		#1;
		sysRst = 1'b0;
		@(posedge mclk);
		#1;
		step(12'h57f);
		repeat (5) step(12'hebf);
		step(12'hc3f);
		$display("test load and burst done");
		for (int i = 0; i < 32; i++)
			step({~i[4:3], i[2:0], 7'h7f});
		$display("test selects done");
		step(12'h57e);
		step(12'hee9);
		step(12'he83);
		step(12'hee8);
		step(12'heff);
		$display("test writes done");
		pulse_reset();
		$display("test reset done");
		repeat (300)
		begin
			v = 12'(rnd() & 32'hf7f | 32'h100);
			step(v);
		end
		$display("test random done");
		repeat (2) @(posedge mclk);
		stop_test();
	end
endmodule : tb

`default_nettype wire
